// ### rtl/bpsg_glue.v
`timescale 1ns/1ps
`include "bpsg_regs.vh"
// Peripheral select decoder, interrupt routing and reset glue
module bpsg_glue #(
    parameter RST_HOLD_CYC = `BPSG_RST_HOLD_CYC  // Power-up hold, shorten in sim
) (
    input  wire       clk_sys_i,                   // System clock
    input  wire       rst_n_i,                     // Async power-up reset
    input  wire       upstream_region_select_n_i,  // Region select from host
    input  wire       passthrough_region_select_n_i, // Fourth region select
    input  wire [2:0] addr_hi_i,                   // Address bits A18..A16
    input  wire [2:0] uart_irq_i,                  // Interrupts, ports 2..4
    input  wire [2:0] irq_mode_en_i,               // Interrupt mode, ports 2..4
    input  wire       reset_line_i,                // Sensed shared reset line
    output reg        reset_line_o,                // Drive value, always low
    output reg        reset_line_oe_o,             // Reset line drive enable
    output reg        passthrough_region_select_n_o, // To connector
    output reg        uart_port4_select_n_o,       // Port 4 select
    output reg        uart_port3_select_n_o,       // Port 3 select
    output reg        uart_port2_select_n_o,       // Port 2 select
    output reg        uart_port1_select_n_o,       // Port 1 select
    output reg        ext_select0_n_o,             // Connector select 0
    output reg        ext_select1_n_o,             // Connector select 1
    output reg        ext_select2_n_o,             // Connector select 2
    output reg        ext_select3_n_o,             // Connector select 3
    output reg        capcomp_channel_a_o,         // Port 2 interrupt out
    output reg        capcomp_channel_b_o,         // Port 3 interrupt out
    output reg        capcomp_channel_c_o,         // Port 4 interrupt out
    output reg  [2:0] capcomp_oe_o                 // Drive enables a..c
);
    wire       rg_oe;        // Reset generator drive
    wire       line_low;     // Reset line seen low
    reg  [7:0] sel_n_d;      // Decoded selects, active low

    // One-hot active-low decode of address code
    function [7:0] dec_sel_n;
        input       en_n;
        input [2:0] code;
        begin
            dec_sel_n = 8'hFF;
            if (!en_n) begin
                dec_sel_n[code] = 1'b0;
            end
        end
    endfunction

    // Power-up reset stretcher
    bpsg_reset_gen #(
        .HOLD_CYC (RST_HOLD_CYC)
    ) u_rst (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n_i),
        .line_i       (reset_line_i),
        .line_oe_o    (rg_oe),
        .line_low_q_o (line_low)
    );

    // Decode, blanked while reset line low
    always @* begin
        if (line_low) begin
            sel_n_d = 8'hFF;
        end else begin
            sel_n_d = dec_sel_n(upstream_region_select_n_i, addr_hi_i);
        end
    end

    // Registered outputs
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_line_o                  <= 1'b0;
            reset_line_oe_o               <= 1'b1;
            passthrough_region_select_n_o <= 1'b1;
            {ext_select3_n_o, ext_select2_n_o, ext_select1_n_o, ext_select0_n_o} <= 4'hF;
            {uart_port1_select_n_o, uart_port2_select_n_o} <= 2'h3;
            {uart_port3_select_n_o, uart_port4_select_n_o} <= 2'h3;
            capcomp_channel_a_o           <= 1'b0;
            capcomp_channel_b_o           <= 1'b0;
            capcomp_channel_c_o           <= 1'b0;
            capcomp_oe_o                  <= 3'h0;
        end else begin
            reset_line_o                  <= 1'b0;
            reset_line_oe_o               <= rg_oe;
            passthrough_region_select_n_o <= passthrough_region_select_n_i;
            // Each UART port on its own 8-byte select
            uart_port4_select_n_o <= sel_n_d[`BPSG_CODE_UART4];
            uart_port3_select_n_o <= sel_n_d[`BPSG_CODE_UART3];
            uart_port2_select_n_o <= sel_n_d[`BPSG_CODE_UART2];
            uart_port1_select_n_o <= sel_n_d[`BPSG_CODE_UART1];
            ext_select0_n_o       <= sel_n_d[`BPSG_CODE_EXT0];
            ext_select1_n_o       <= sel_n_d[`BPSG_CODE_EXT1];
            ext_select2_n_o       <= sel_n_d[`BPSG_CODE_EXT2];
            ext_select3_n_o       <= sel_n_d[`BPSG_CODE_EXT3];
            // Interrupt routing, masked when mode off
            capcomp_channel_a_o   <= uart_irq_i[0] & irq_mode_en_i[0];
            capcomp_channel_b_o   <= uart_irq_i[1] & irq_mode_en_i[1];
            capcomp_channel_c_o   <= uart_irq_i[2] & irq_mode_en_i[2];
            capcomp_oe_o          <= irq_mode_en_i;
        end
    end
endmodule // bpsg_glue

// ### rtl/bpsg_regs.vh
// How it works
// - At most one decoded select low, only when upstream low
// - Codes 0-3 UART ports 4..1, 4-7 external
// - Fourth region select passes through one register stage, one clock late
// - Enabled UART interrupts drive capcomp channels a-c
// - Disabled interrupt mode leaves controller pin undriven
// - Power-up holds reset line low over 50 ms
// - Each UART port has own select, 8 bytes
`ifndef BPSG_REGS_VH
`define BPSG_REGS_VH
`define BPSG_SEL_COUNT     8
`define BPSG_CODE_UART4    3'h0
`define BPSG_CODE_UART3    3'h1
`define BPSG_CODE_UART2    3'h2
`define BPSG_CODE_UART1    3'h3
`define BPSG_CODE_EXT0     3'h4
`define BPSG_CODE_EXT1     3'h5
`define BPSG_CODE_EXT2     3'h6
`define BPSG_CODE_EXT3     3'h7
`define BPSG_UART_SPAN_B   8
`define BPSG_CLK_NS        10
`define BPSG_RST_HOLD_MS   50
`define BPSG_RST_HOLD_CYC  ((`BPSG_RST_HOLD_MS * 1000000) / `BPSG_CLK_NS + 1)
`endif

// ### rtl/bpsg_reset_gen.v
`timescale 1ns/1ps
`include "bpsg_regs.vh"
// Power-up reset stretcher, drives shared line open-drain
module bpsg_reset_gen #(
    parameter HOLD_CYC = `BPSG_RST_HOLD_CYC,  // Cycles the line is held low
    parameter CNT_W    = 23                   // Counter width
) (
    input  wire clk_sys_i,      // System clock
    input  wire rst_n_i,        // Power-up reset
    input  wire line_i,         // Sensed level of shared reset line
    output reg  line_oe_o,      // Drive line low while high
    output reg  line_low_q_o    // Registered line low indication
);
    localparam integer     HOLD_M1   = HOLD_CYC - 1;          // Last count, full width
    localparam [CNT_W-1:0] HOLD_LAST = HOLD_M1[CNT_W-1:0];    // Cut to counter width
    reg [CNT_W-1:0] cnt_q;      // Hold counter
    reg             busy_q;     // Still holding after power-up

    // Counts the hold period, then releases the line
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q        <= {CNT_W{1'b0}};
            busy_q       <= 1'b1;
            line_oe_o    <= 1'b1;
            line_low_q_o <= 1'b1;
        end else begin
            line_low_q_o <= ~line_i | busy_q;
            if (busy_q) begin
                if (cnt_q == HOLD_LAST) begin
                    busy_q    <= 1'b0;
                    line_oe_o <= 1'b0;
                end else begin
                    cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // bpsg_reset_gen

// ### verification/bpsg_glue_chk.sv
`timescale 1ns/1ps
// Port-level checks of decode, routing and reset glue
module bpsg_glue_chk (
    input wire logic       clk_sys_i, rst_n_i, upstream_region_select_n_i, passthrough_region_select_n_i,
    input wire logic       reset_line_i, reset_line_oe_o, passthrough_region_select_n_o,
    input wire logic       uart_port4_select_n_o, uart_port3_select_n_o, uart_port2_select_n_o,
    input wire logic       uart_port1_select_n_o, ext_select0_n_o, ext_select1_n_o, ext_select2_n_o,
    input wire logic       ext_select3_n_o, capcomp_channel_a_o, capcomp_channel_b_o, capcomp_channel_c_o,
    input wire logic [2:0] addr_hi_i, uart_irq_i, irq_mode_en_i, capcomp_oe_o
);
    // Selects packed so bit n answers address code n
    wire [7:0] sel = {ext_select3_n_o, ext_select2_n_o, ext_select1_n_o, ext_select0_n_o,
        uart_port1_select_n_o, uart_port2_select_n_o, uart_port3_select_n_o, uart_port4_select_n_o};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Reset wire high two edges, region select low
    sequence req_ok_s;
        reset_line_i ##1 (reset_line_i && !upstream_region_select_n_i);
    endsequence
    sel_onehot_a: assert property ($onehot0(~sel)) else $error("two selects low");
    sel_decode_a: assert property (req_ok_s |=> sel == ~(8'h01 << $past(addr_hi_i))) else $error("decode");
    sel_idle_a: assert property (upstream_region_select_n_i |=> &sel) else $error("select unasked");
    pass_thru_a: assert property ($past(rst_n_i) |->
        passthrough_region_select_n_o == $past(passthrough_region_select_n_i)) else $error("passthrough");
    irq_route_a: assert property ($past(rst_n_i) |-> {capcomp_channel_c_o, capcomp_channel_b_o,
        capcomp_channel_a_o} == ($past(uart_irq_i) & $past(irq_mode_en_i))) else $error("irq route");
    irq_float_a: assert property ($past(rst_n_i) |-> capcomp_oe_o == $past(irq_mode_en_i)) else $error("oe");
    rst_hold_a: assert property ($rose(rst_n_i) |-> reset_line_oe_o [*8]) else $error("hold short");
    line_gate_a: assert property (!reset_line_i |=> ##1 &sel) else $error("select in reset");
endmodule // bpsg_glue_chk
bind bpsg_glue bpsg_glue_chk bpsg_glue_chk_i (.*);

// ### verification/bpsg_host_mdl.sv
`timescale 1ns/1ps
// Shared reset wire: pull-up, parties only pull low
module bpsg_host_mdl (
    input  wire logic board_oe_i,  // Board pulls wire low
    input  wire logic push_low_i,  // External reset request
    output wire logic line_o       // Resolved wire level
);
    assign line_o = !(board_oe_i || push_low_i);
endmodule // bpsg_host_mdl

// ### verification/bpsg_glue_tb.sv
`timescale 1ns/1ps
module bpsg_glue_tb;
    logic       clk_sys_i = 0, rst_n_i = 0, upstream_region_select_n_i = 1, passthrough_region_select_n_i = 1;
    logic       push_q = 0, reset_line_i, reset_line_o, reset_line_oe_o, passthrough_region_select_n_o;
    logic       uart_port4_select_n_o, uart_port3_select_n_o, uart_port2_select_n_o, uart_port1_select_n_o;
    logic       ext_select0_n_o, ext_select1_n_o, ext_select2_n_o, ext_select3_n_o;
    logic       capcomp_channel_a_o, capcomp_channel_b_o, capcomp_channel_c_o;
    logic [2:0] addr_hi_i = 0, uart_irq_i = 0, irq_mode_en_i = 0, capcomp_oe_o;
    int         err_count = 0, compares = 0;
    // Design with a short power-up hold
    bpsg_glue #(.RST_HOLD_CYC(20)) bpsg_glue_i (.*);
    bpsg_host_mdl bpsg_host_mdl_i (.board_oe_i(reset_line_oe_o), .push_low_i(push_q), .line_o(reset_line_i));
    wire [14:0] got = {ext_select3_n_o, ext_select2_n_o, ext_select1_n_o, ext_select0_n_o,
        uart_port1_select_n_o, uart_port2_select_n_o, uart_port3_select_n_o, uart_port4_select_n_o,
        passthrough_region_select_n_o,
        capcomp_channel_c_o, capcomp_channel_b_o, capcomp_channel_a_o, capcomp_oe_o};
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // Expected outputs for inputs taken at the last edge
    function automatic logic [14:0] expect_out();
        expect_out = {upstream_region_select_n_i ? 8'hff : ~(8'h01 << addr_hi_i), passthrough_region_select_n_i,
            uart_irq_i & irq_mode_en_i, irq_mode_en_i};
    endfunction
    task automatic check(input logic [14:0] g, input logic [14:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One setting driven, answer compared at the falling edge after the next rising edge
    task automatic step(input logic up, input logic [2:0] a);
        @(posedge clk_sys_i);
        {upstream_region_select_n_i, addr_hi_i} <= {up, a};
        {passthrough_region_select_n_i, uart_irq_i, irq_mode_en_i} <= 7'($urandom);
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        check(got, expect_out());
    endtask
    task automatic close_out();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hab31_331f));
        repeat (4) @(posedge clk_sys_i);
        {rst_n_i, upstream_region_select_n_i} <= 2'b10;
        repeat (10) @(negedge clk_sys_i);
        check({got[14:7], reset_line_oe_o}, 9'h1ff);
        check(reset_line_o, 0);
        repeat (15) @(negedge clk_sys_i);
        check(reset_line_oe_o, 0);
        for (int a = 0; a < 8; a++) step(0, 3'(a));
        repeat (200) step(1'($urandom), 3'($urandom));
        step(0, 3'h6);
        @(posedge clk_sys_i);
        push_q <= 1;
        repeat (4) @(negedge clk_sys_i);
        check(got[14:7], 8'hff);
        @(posedge clk_sys_i);
        push_q <= 0;
        repeat (30) @(posedge clk_sys_i);
        step(0, 3'h5);
        close_out();
    end
    // Hang guard
    initial begin
        #50000;
        err_count++;
        close_out();
    end
endmodule // bpsg_glue_tb
